/* File: include/prpo_params.svh */
/*
  Constants of the reset and power-ok logic: register offsets, field
  positions, reset values, voltage codes in millivolts, timing figures.
  Assumes a 100 MHz MCLK and a 32-bit APB with 8-bit byte addresses.
*/
`ifndef PRPO_PARAMS_SVH
`define PRPO_PARAMS_SVH
// Contract
// - hold reset low while always-on rail below 2.4 V; release after delay above 2.52 V.
// - reset delay set by board capacitor; 1 nF gives about 100 ms.
// - debounced warm-reset input (about 30 ms) also triggers the system reset.
// - system reset is open-drain: only pulled low or left undriven.
// - supply-fail and battery-low flags set below 1 V, clear 50 mV higher.
// - warm reset reverts only the core buck setting; other registers keep contents.
// - core setting reverts on warm reset, rail low, undervoltage lock or reset.
// - regulator select pins captured once at power-up; captured values are used.
// - select pair {b,a} picks initial regulator A and B voltages per table.
// - both regulator voltages may be rewritten by software after power-up.
// - power-ok held low at power-up until the last enabled rail regulates; here it is left undriven until an enabled rail reports low.
// - enabled rail leaving regulation drives power-ok low and sets its fault bit.
// - reading fault status while power-ok low releases the output.
// - that read does not clear the fault bit while the rail stays low.
// - a mask register gates faults; rail faults unmasked by default.
// - converter enable 0 turns it off, 1 turns it on.
// - memory buck default 1.8 V with pin low, 3.3 V with pin high.
// - system buck default 1.8 V with pin low, 3.3 V with pin high.
// - core buck default 1.2 V with pin low, 1.6 V with pin high.
// - reset output driven low from power-up before any rail is judged.
// - mask bit 1 stops its fault bit from driving power-ok.

`define PRPO_CLK_MHZ 100
`define PRPO_CYC_PER_MS (`PRPO_CLK_MHZ * 1000)
`define PRPO_DLY_MS_PER_NF 100
`define PRPO_DEBOUNCE_MS 30

`define PRPO_OFF_STATUS 8'h00
`define PRPO_OFF_MASK 8'h04
`define PRPO_OFF_CORE 8'h08
`define PRPO_OFF_LDO 8'h0C
`define PRPO_OFF_DELAY 8'h10
`define PRPO_OFF_BUCKS 8'h14

`define PRPO_MASK_RST 7'h60
`define PRPO_CAP_RST 8'h01
`define PRPO_LDO_B_LSB 16

`define PRPO_MV_1V2 12'h4B0
`define PRPO_MV_1V3 12'h514
`define PRPO_MV_1V6 12'h640
`define PRPO_MV_1V8 12'h708
`define PRPO_MV_2V8 12'hAF0
`define PRPO_MV_3V3 12'hCE4
`endif

/* File: include/prpo_pkg.sv */
/*
  Types of the reset and power-ok logic.
  Assumes prpo_params.svh supplies the numeric constants.
*/
`default_nettype none
package prpo_pkg;
  typedef enum logic [1:0] {
    PRPO_HOLD = 2'b00,
    PRPO_DELAY = 2'b01,
    PRPO_RUN = 2'b10
  } prpo_rst_e;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } prpo_apb_s;

  typedef struct packed {
    prpo_rst_e rst;
    logic [23:0] unit;
    logic [7:0] nf;
    logic captured;
    logic [4:0] strap;
    logic [6:0] fault;
    logic [6:0] mask;
    logic released;
    logic drv_rst;
    logic drv_int;
    logic [3:0] on;
    logic [7:0] cap_nf;
    logic [11:0] core_mv;
    logic [11:0] sys_mv;
    logic [11:0] mem_mv;
    logic [11:0] a_mv;
    logic [11:0] b_mv;
    logic [31:0] prdata;
  } prpo_state_s;

  typedef struct packed {
    logic level;
    logic [23:0] cnt;
  } prpo_db_s;
endpackage : prpo_pkg
`default_nettype wire

/* File: design/prpo_hyst.sv */
/*
  Threshold flag with hysteresis from two comparator levels.
  Assumes below and above never both high; below wins if they are.
*/
`timescale 1ns/10ps
`default_nettype none
module prpo_hyst #(
  parameter logic RST_FLAG = 1'b0
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic BELOW,
  input wire logic ABOVE,
  output logic FLAG
);
  logic flag;
  logic next_flag;

  always_comb begin
    next_flag = flag;
    if (BELOW) begin
      next_flag = 1'b1;
    end else if (ABOVE) begin
      next_flag = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      flag <= RST_FLAG;
    end else begin
      flag <= next_flag;
    end
  end

  assign FLAG = flag;

  // the release edge still loads the reset value, so it starts no attempt
  chk_hyst_set_clear: assert property (@(posedge MCLK) disable iff (!RST_N)
    RST_N |-> ((BELOW |=> flag) and ((!BELOW && ABOVE) |=> !flag)
    and ((!BELOW && !ABOVE) |=> $stable(flag))))
    else $error("threshold flag broke hysteresis");
endmodule : prpo_hyst
`default_nettype wire

/* File: design/prpo_debounce.sv */
/*
  Level filter for the warm-reset input.
  Assumes the input is synchronous to MCLK; CYCLES is the filter time.
*/
`timescale 1ns/10ps
`default_nettype none
module prpo_debounce #(
  parameter int CYCLES = 3000000
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic IN,
  output logic OUT
);
  localparam logic [23:0] LAST = 24'(CYCLES - 1);
  prpo_pkg::prpo_db_s st;
  prpo_pkg::prpo_db_s next_st;

  if (CYCLES < 1 || CYCLES > 16777216) begin : g_bad
    $error("debounce CYCLES out of range");
  end

  always_comb begin
    next_st = st;
    if (IN == st.level) begin
      next_st.cnt = 24'h000000;
    end else if (st.cnt == LAST) begin
      next_st.level = IN;
      next_st.cnt = 24'h000000;
    end else begin
      next_st.cnt = st.cnt + 24'h000001;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign OUT = st.level;

  chk_db_full_time: assert property (@(posedge MCLK) disable iff (!RST_N)
    $changed(st.level) |-> $past(st.cnt) == LAST)
    else $error("filtered level changed before filter time");
endmodule : prpo_debounce
`default_nettype wire

/* File: design/prpo_ctrl.sv */
/*
  Reset and power-ok control: delayed open-drain system reset,
  warm-reset filter, strap capture, converter settings, fault status
  with mask and read release, APB register slave.
  Assumes comparator levels arrive synchronous to MCLK and that the
  board pulls both open-drain outputs high.
*/
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "prpo_params.svh"
module prpo_ctrl #(
  parameter int RST_CYC_PER_NF = `PRPO_DLY_MS_PER_NF * `PRPO_CYC_PER_MS,
  parameter int DEBOUNCE_CYC = `PRPO_DEBOUNCE_MS * `PRPO_CYC_PER_MS
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic AON_BELOW_FALL,
  input wire logic AON_ABOVE_RISE,
  input wire logic SFAIL_BELOW,
  input wire logic SFAIL_ABOVE,
  input wire logic BLOW_BELOW,
  input wire logic BLOW_ABOVE,
  input wire logic INPUT_UNDERVOLTAGE_LOCK,
  input wire logic WARM_RESET_IN,
  input wire logic CORE_BUCK_DEFAULT_SEL,
  input wire logic SYSTEM_BUCK_DEFAULT_SEL,
  input wire logic MEMORY_BUCK_DEFAULT_SEL,
  input wire logic REG_A_DEFAULT_SEL,
  input wire logic REG_B_DEFAULT_SEL,
  input wire logic CORE_BUCK_ENABLE,
  input wire logic SYSTEM_BUCK_ENABLE,
  input wire logic MEMORY_BUCK_ENABLE,
  input wire logic REG_ENABLE,
  input wire logic [4:0] RAIL_LOW,
  input wire logic SYSTEM_RESET_N_I,
  output logic SYSTEM_RESET_N_O,
  output logic SYSTEM_RESET_N_OE_N,
  input wire logic POWER_OK_N_I,
  output logic POWER_OK_N_O,
  output logic POWER_OK_N_OE_N,
  output logic SUPPLY_FAIL_FLAG,
  output logic BATTERY_LOW_FLAG,
  output logic CORE_BUCK_ON,
  output logic SYSTEM_BUCK_ON,
  output logic MEMORY_BUCK_ON,
  output logic REG_ON,
  output logic [11:0] CORE_BUCK_OUTPUT,
  output logic [11:0] SYSTEM_BUCK_OUTPUT,
  output logic [11:0] MEMORY_BUCK_OUTPUT,
  output logic [11:0] REG_A_OUTPUT,
  output logic [11:0] REG_B_OUTPUT
);
  localparam logic [23:0] UNIT_LAST = 24'(RST_CYC_PER_NF - 1);

  if (RST_CYC_PER_NF < 1 || RST_CYC_PER_NF > 16777216) begin : g_bad
    $error("RST_CYC_PER_NF out of range");
  end

  // ----------------------------------------------------------------
  // comparators and filter
  // ----------------------------------------------------------------
  logic aon_low;
  logic sfail;
  logic blow;
  logic warm;

  // rail assumed low until the comparator says otherwise
  prpo_hyst #(.RST_FLAG(1'b1)) u_aon (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .BELOW(AON_BELOW_FALL),
    .ABOVE(AON_ABOVE_RISE),
    .FLAG(aon_low)
  );

  prpo_hyst #(.RST_FLAG(1'b0)) u_sfail (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .BELOW(SFAIL_BELOW),
    .ABOVE(SFAIL_ABOVE),
    .FLAG(sfail)
  );

  prpo_hyst #(.RST_FLAG(1'b0)) u_blow (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .BELOW(BLOW_BELOW),
    .ABOVE(BLOW_ABOVE),
    .FLAG(blow)
  );

  prpo_debounce #(.CYCLES(DEBOUNCE_CYC)) u_warm (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .IN(WARM_RESET_IN),
    .OUT(warm)
  );

  // ----------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------
  function automatic logic [11:0] ldo_a_mv(input logic [1:0] ba);
    case (ba)
      2'b01: ldo_a_mv = `PRPO_MV_2V8;
      2'b11: ldo_a_mv = `PRPO_MV_1V8;
      default: ldo_a_mv = `PRPO_MV_1V3;
    endcase
  endfunction : ldo_a_mv

  function automatic logic [11:0] ldo_b_mv(input logic [1:0] ba);
    ldo_b_mv = (ba == 2'b10) ? `PRPO_MV_1V8 : `PRPO_MV_3V3;
  endfunction : ldo_b_mv

  function automatic logic [11:0] bus_mv(input logic hi);
    bus_mv = hi ? `PRPO_MV_3V3 : `PRPO_MV_1V8;
  endfunction : bus_mv

  function automatic logic [11:0] core_def(input logic hi);
    core_def = hi ? `PRPO_MV_1V6 : `PRPO_MV_1V2;
  endfunction : core_def

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  prpo_pkg::prpo_apb_s req;
  logic hit;
  logic acc;
  logic wr;
  logic rd_status;
  logic [31:0] rmux;

  assign req = '{sel: PSEL, en: PENABLE, wr: PWRITE, addr: PADDR, wdata: PWDATA};
  assign acc = req.sel && req.en;
  assign wr = acc && req.wr && hit;
  assign rd_status = acc && !req.wr && req.addr == `PRPO_OFF_STATUS;

  prpo_pkg::prpo_state_s st;
  prpo_pkg::prpo_state_s next_st;

  always_comb begin
    hit = 1'b1;
    rmux = 32'h00000000;
    case (req.addr)
      `PRPO_OFF_STATUS:
        rmux = {21'h00000, warm, SYSTEM_RESET_N_I, st.released, st.fault, 1'b0};
      `PRPO_OFF_MASK: rmux = {24'h000000, st.mask, 1'b0};
      `PRPO_OFF_CORE: rmux = {20'h00000, st.core_mv};
      `PRPO_OFF_LDO: rmux = {4'h0, st.b_mv, 4'h0, st.a_mv};
      `PRPO_OFF_DELAY: rmux = {24'h000000, st.cap_nf};
      `PRPO_OFF_BUCKS: rmux = {4'h0, st.mem_mv, 4'h0, st.sys_mv};
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [6:0] fault_now;
  logic [6:0] active;
  logic new_fault;
  logic revert;

  always_comb begin
    next_st = st;
    // fault bits read zero for disabled rails
    fault_now = {sfail, blow, RAIL_LOW & {st.on[3:1], st.on[0], st.on[0]}};
    active = fault_now & ~st.mask;
    new_fault = |(active & ~(st.fault & ~st.mask));
    revert = warm || aon_low || INPUT_UNDERVOLTAGE_LOCK || st.rst != prpo_pkg::PRPO_RUN;

    next_st.on = {CORE_BUCK_ENABLE, SYSTEM_BUCK_ENABLE, MEMORY_BUCK_ENABLE, REG_ENABLE};
    next_st.fault = fault_now;

    // straps are taken once, on the first edge after reset release
    if (!st.captured) begin
      next_st.captured = 1'b1;
      next_st.strap = {CORE_BUCK_DEFAULT_SEL, SYSTEM_BUCK_DEFAULT_SEL,
        MEMORY_BUCK_DEFAULT_SEL, REG_B_DEFAULT_SEL, REG_A_DEFAULT_SEL};
      next_st.a_mv = ldo_a_mv({REG_B_DEFAULT_SEL, REG_A_DEFAULT_SEL});
      next_st.b_mv = ldo_b_mv({REG_B_DEFAULT_SEL, REG_A_DEFAULT_SEL});
      next_st.sys_mv = bus_mv(SYSTEM_BUCK_DEFAULT_SEL);
      next_st.mem_mv = bus_mv(MEMORY_BUCK_DEFAULT_SEL);
      next_st.core_mv = core_def(CORE_BUCK_DEFAULT_SEL);
    end else if (wr && req.addr == `PRPO_OFF_LDO) begin
      next_st.a_mv = req.wdata[11:0];
      next_st.b_mv = req.wdata[`PRPO_LDO_B_LSB +: 12];
    end

    // only the core setting is touched by the revert conditions
    if (st.captured && revert) begin
      next_st.core_mv = core_def(st.strap[4]);
    end else if (st.captured && wr && req.addr == `PRPO_OFF_CORE) begin
      next_st.core_mv = req.wdata[11:0];
    end

    if (wr && req.addr == `PRPO_OFF_MASK) begin
      next_st.mask = req.wdata[7:1];
    end
    if (wr && req.addr == `PRPO_OFF_DELAY) begin
      next_st.cap_nf = req.wdata[7:0];
    end

    // reset sequencer
    case (st.rst)
      prpo_pkg::PRPO_HOLD: begin
        next_st.unit = 24'h000000;
        next_st.nf = 8'h00;
        if (st.captured && !aon_low && !warm) begin
          next_st.rst = prpo_pkg::PRPO_DELAY;
        end
      end
      prpo_pkg::PRPO_DELAY: begin
        if (aon_low || warm) begin
          next_st.rst = prpo_pkg::PRPO_HOLD;
        end else if (st.unit == UNIT_LAST) begin
          next_st.unit = 24'h000000;
          next_st.nf = st.nf + 8'h01;
          // a zero capacitor code counts as one unit
          if (st.nf + 8'h01 >= st.cap_nf) begin
            next_st.rst = prpo_pkg::PRPO_RUN;
          end
        end else begin
          next_st.unit = st.unit + 24'h000001;
        end
      end
      prpo_pkg::PRPO_RUN: begin
        if (aon_low || warm) begin
          next_st.rst = prpo_pkg::PRPO_HOLD;
        end
      end
      default: next_st.rst = prpo_pkg::PRPO_HOLD;
    endcase
    next_st.drv_rst = next_st.rst != prpo_pkg::PRPO_RUN;

    // a fresh fault beats a releasing read in the same cycle
    if (new_fault || !(|active)) begin
      next_st.released = 1'b0;
    end else if (rd_status && st.drv_int) begin
      next_st.released = 1'b1;
    end
    next_st.drv_int = (|active) && !next_st.released;

    next_st.prdata = (req.sel && !req.en) ? rmux : st.prdata;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
      st.rst <= prpo_pkg::PRPO_HOLD;
      st.drv_rst <= 1'b1;
      st.mask <= `PRPO_MASK_RST;
      st.cap_nf <= `PRPO_CAP_RST;
      st.core_mv <= `PRPO_MV_1V2;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // pads only ever pull low; pull-ups give the high level
  assign SYSTEM_RESET_N_O = 1'b0;
  assign SYSTEM_RESET_N_OE_N = !st.drv_rst;
  assign POWER_OK_N_O = 1'b0;
  assign POWER_OK_N_OE_N = !st.drv_int;
  assign PRDATA = st.prdata;
  assign PREADY = 1'b1;
  assign PSLVERR = acc && !hit;
  assign SUPPLY_FAIL_FLAG = sfail;
  assign BATTERY_LOW_FLAG = blow;
  assign {CORE_BUCK_ON, SYSTEM_BUCK_ON, MEMORY_BUCK_ON, REG_ON} = st.on;
  assign CORE_BUCK_OUTPUT = st.core_mv;
  assign SYSTEM_BUCK_OUTPUT = st.sys_mv;
  assign MEMORY_BUCK_OUTPUT = st.mem_mv;
  assign REG_A_OUTPUT = st.a_mv;
  assign REG_B_OUTPUT = st.b_mv;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_rail_low_hold: assert property (@(posedge MCLK) disable iff (!RST_N)
    aon_low |=> !SYSTEM_RESET_N_OE_N)
    else $error("reset released while always-on rail low");

  chk_release_delay: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(SYSTEM_RESET_N_OE_N) |-> $past(st.rst) == prpo_pkg::PRPO_DELAY
      && $past(st.unit) == UNIT_LAST && $past(st.nf) + 8'h01 >= st.cap_nf)
    else $error("reset released before the programmed delay");

  chk_warm_trigger: assert property (@(posedge MCLK) disable iff (!RST_N)
    warm |=> !SYSTEM_RESET_N_OE_N ##1 !SYSTEM_RESET_N_OE_N)
    else $error("warm reset did not hold system reset");

  chk_open_drain: assert property (@(posedge MCLK) disable iff (!RST_N)
    !SYSTEM_RESET_N_O && !POWER_OK_N_O)
    else $error("open-drain pin driven high");

  chk_warm_keeps_ldo: assert property (@(posedge MCLK) disable iff (!RST_N)
    (warm && st.captured && !wr) |=> $stable(st.a_mv) && $stable(st.b_mv)
      && $stable(st.mask) && st.core_mv == core_def(st.strap[4]))
    else $error("warm reset disturbed other settings");

  chk_core_revert: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st.captured && (INPUT_UNDERVOLTAGE_LOCK || aon_low))
      |=> CORE_BUCK_OUTPUT == core_def(st.strap[4]))
    else $error("core setting did not revert");

  chk_strap_once: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(st.captured) |-> $stable(st.strap))
    else $error("straps re-sampled after power-up");

  chk_ldo_table: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(st.captured) |-> REG_A_OUTPUT == ldo_a_mv(st.strap[1:0])
      && REG_B_OUTPUT == ldo_b_mv(st.strap[1:0]))
    else $error("regulator defaults do not match straps");

  chk_ldo_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    (st.captured && wr && req.addr == `PRPO_OFF_LDO)
      |=> REG_A_OUTPUT == $past(req.wdata[11:0]))
    else $error("regulator setting write lost");

  chk_ok_release: assert property (@(posedge MCLK) disable iff (!RST_N)
    !(|active) |=> POWER_OK_N_OE_N)
    else $error("power-ok held low with all rails good");

  chk_fault_drive: assert property (@(posedge MCLK) disable iff (!RST_N)
    new_fault |=> !POWER_OK_N_OE_N && st.fault == $past(fault_now))
    else $error("new rail fault not signalled");

  chk_read_release: assert property (@(posedge MCLK) disable iff (!RST_N)
    (rd_status && st.drv_int && !new_fault) |=> POWER_OK_N_OE_N)
    else $error("status read did not release power-ok");

  chk_read_keeps: assert property (@(posedge MCLK) disable iff (!RST_N)
    rd_status |=> st.fault == $past(fault_now))
    else $error("status read altered fault bits");

  chk_mask_gate: assert property (@(posedge MCLK) disable iff (!RST_N)
    ((fault_now & ~st.mask) == 7'h00 && !wr) |=> POWER_OK_N_OE_N)
    else $error("masked fault drove power-ok");

  chk_enable_follow: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 CORE_BUCK_ON == $past(CORE_BUCK_ENABLE) && REG_ON == $past(REG_ENABLE))
    else $error("converter enable not followed");

  chk_bucks_default: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(st.captured) |-> MEMORY_BUCK_OUTPUT == bus_mv(st.strap[2])
      && SYSTEM_BUCK_OUTPUT == bus_mv(st.strap[3])
      && CORE_BUCK_OUTPUT == core_def(st.strap[4]))
    else $error("buck defaults do not match straps");

  chk_power_up_low: assert property (@(posedge MCLK) disable iff (!RST_N)
    !st.captured |-> !SYSTEM_RESET_N_OE_N ##1 !SYSTEM_RESET_N_OE_N)
    else $error("reset not driven low at power-up");
endmodule : prpo_ctrl
`default_nettype wire

/* File: verif/prpo_host.sv */
/*
  Host processor model: resolves the two open-drain pins and raises
  the converter enables one after another once reset is released.
  Assumes board pull-ups on both pins and a shared MCLK.
*/
`timescale 1ns/10ps
`default_nettype none
module prpo_host (
  input wire logic MCLK,
  input wire logic RST_OE_N,
  input wire logic RST_O,
  input wire logic OK_OE_N,
  input wire logic OK_O,
  output logic RST_PIN,
  output logic OK_PIN,
  output logic [3:0] EN
);
  // ----------------------------------------
  // pins and power-up order
  // ----------------------------------------
  // pull-up supplies the high level, never the device
  assign RST_PIN = RST_OE_N ? 1'b1 : RST_O;
  assign OK_PIN = OK_OE_N ? 1'b1 : OK_O;
  initial EN = 4'h0;
  // staggered so each converter enable comes up in its own cycle
  always @(posedge MCLK) begin
    if (RST_PIN !== 1'b1) EN <= 4'h0;
    else EN <= {EN[2:0], 1'b1};
  end
endmodule : prpo_host
`default_nettype wire

/* File: verif/test_prpo_ctrl.sv */
/*
  Self-checking bench of prpo_ctrl with the host model.
  Assumes prpo_params.svh on the include path; short timing parameters.
*/
`timescale 1ns/10ps
`default_nettype none
`include "prpo_params.svh"
module test_prpo_ctrl;
  logic MCLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic AON_BELOW_FALL = 1'b0, AON_ABOVE_RISE = 1'b1, SFAIL_BELOW = 1'b0, SFAIL_ABOVE = 1'b1;
  logic BLOW_BELOW = 1'b0, BLOW_ABOVE = 1'b1, INPUT_UNDERVOLTAGE_LOCK = 1'b0;
  logic WARM_RESET_IN = 1'b0, CORE_BUCK_DEFAULT_SEL = 1'b0, SYSTEM_BUCK_DEFAULT_SEL = 1'b0;
  logic MEMORY_BUCK_DEFAULT_SEL = 1'b0, REG_A_DEFAULT_SEL = 1'b0, REG_B_DEFAULT_SEL = 1'b0;
  logic [4:0] RAIL_LOW = 5'h1F;
  logic [31:0] PRDATA, q, wa, seed = 32'h8ECF484D;
  logic PREADY, PSLVERR, SYSTEM_RESET_N_I, SYSTEM_RESET_N_O, SYSTEM_RESET_N_OE_N, POWER_OK_N_I;
  logic POWER_OK_N_O, POWER_OK_N_OE_N, SUPPLY_FAIL_FLAG, BATTERY_LOW_FLAG, CORE_BUCK_ON, err;
  logic SYSTEM_BUCK_ON, MEMORY_BUCK_ON, REG_ON, CORE_BUCK_ENABLE, SYSTEM_BUCK_ENABLE;
  logic MEMORY_BUCK_ENABLE, REG_ENABLE;
  logic [11:0] CORE_BUCK_OUTPUT, SYSTEM_BUCK_OUTPUT, MEMORY_BUCK_OUTPUT, REG_A_OUTPUT;
  logic [11:0] REG_B_OUTPUT, core_def;
  logic [3:0] en;
  int num_errors = 0, checks = 0, n;

  prpo_ctrl #(.RST_CYC_PER_NF(20), .DEBOUNCE_CYC(8)) dut (.*);
  prpo_host host (.MCLK(MCLK), .RST_OE_N(SYSTEM_RESET_N_OE_N), .RST_O(SYSTEM_RESET_N_O),
    .OK_OE_N(POWER_OK_N_OE_N), .OK_O(POWER_OK_N_O), .RST_PIN(SYSTEM_RESET_N_I),
    .OK_PIN(POWER_OK_N_I), .EN(en));
  assign {CORE_BUCK_ENABLE, SYSTEM_BUCK_ENABLE, MEMORY_BUCK_ENABLE, REG_ENABLE} = en;
  always #5 MCLK = ~MCLK;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic stop_test;
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs

  // model of the regulator pair {b,a} -> {reg_b mV, reg_a mV}
  function automatic logic [23:0] ldo_mv(input logic [1:0] ba);
    case (ba)
      2'b00: return {`PRPO_MV_3V3, `PRPO_MV_1V3};
      2'b01: return {`PRPO_MV_3V3, `PRPO_MV_2V8};
      2'b10: return {`PRPO_MV_1V8, `PRPO_MV_1V3};
      default: return {`PRPO_MV_3V3, `PRPO_MV_1V8};
    endcase
  endfunction : ldo_mv

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge MCLK);
      if (PREADY === 1'b1) break;
    end
    if (k == 20) begin
      num_errors++;
      stop_test();
    end
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : apb

  // counts cycles until the reset pin shows lvl, checked mid-cycle
  task automatic wait_pin(input logic lvl, input int lim);
    n = 0;
    @(negedge MCLK);
    while (SYSTEM_RESET_N_I !== lvl) begin
      if (++n > lim) begin
        num_errors++;
        stop_test();
      end
      @(negedge MCLK);
    end
    @(posedge MCLK);
  endtask : wait_pin

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      RST_N <= 1'b0;
      {CORE_BUCK_DEFAULT_SEL, SYSTEM_BUCK_DEFAULT_SEL, MEMORY_BUCK_DEFAULT_SEL} <= seed[2:0];
      {REG_B_DEFAULT_SEL, REG_A_DEFAULT_SEL} <= i[1:0];
      core_def = seed[2] ? `PRPO_MV_1V6 : `PRPO_MV_1V2;
      repeat (5) @(posedge MCLK);
      cmp(SYSTEM_RESET_N_I, 1'b0);
      RST_N <= 1'b1;
      @(posedge MCLK);
      {REG_B_DEFAULT_SEL, REG_A_DEFAULT_SEL} <= ~i[1:0];
      @(negedge MCLK);
      cmp({REG_B_OUTPUT, REG_A_OUTPUT}, ldo_mv(i[1:0]));
      cmp(CORE_BUCK_OUTPUT, core_def);
      cmp(SYSTEM_BUCK_OUTPUT, seed[1] ? `PRPO_MV_3V3 : `PRPO_MV_1V8);
      cmp(MEMORY_BUCK_OUTPUT, seed[0] ? `PRPO_MV_3V3 : `PRPO_MV_1V8);
      @(posedge MCLK);
      apb(1'b0, `PRPO_OFF_MASK, 32'h0);
      cmp(q, {`PRPO_MASK_RST, 1'b0});
      apb(1'b0, `PRPO_OFF_DELAY, 32'h0);
      cmp(q, `PRPO_CAP_RST);
      wait_pin(1'b1, 40);
      cmp({REG_B_OUTPUT, REG_A_OUTPUT}, ldo_mv(i[1:0]));
    end
    apb(1'b1, `PRPO_OFF_DELAY, 32'h2);
    apb(1'b1, `PRPO_OFF_CORE, 32'h5DC);
    AON_BELOW_FALL <= 1'b1;
    AON_ABOVE_RISE <= 1'b0;
    wait_pin(1'b0, 3);
    cmp(CORE_BUCK_OUTPUT, core_def);
    AON_BELOW_FALL <= 1'b0;
    AON_ABOVE_RISE <= 1'b1;
    wait_pin(1'b1, 60);
    cmp(n >= 40 && n <= 44, 1'b1);
    wa = xs(seed) & 32'h0FFF0FFF;
    apb(1'b1, `PRPO_OFF_LDO, wa);
    apb(1'b1, `PRPO_OFF_CORE, 32'h5DC);
    WARM_RESET_IN <= 1'b1;
    repeat (5) @(posedge MCLK);
    WARM_RESET_IN <= 1'b0;
    repeat (12) @(posedge MCLK);
    cmp({SYSTEM_RESET_N_I, CORE_BUCK_OUTPUT}, 13'h15DC);
    WARM_RESET_IN <= 1'b1;
    wait_pin(1'b0, 14);
    cmp(CORE_BUCK_OUTPUT, core_def);
    cmp({REG_B_OUTPUT, REG_A_OUTPUT}, {wa[27:16], wa[11:0]});
    WARM_RESET_IN <= 1'b0;
    wait_pin(1'b1, 80);
    apb(1'b1, `PRPO_OFF_CORE, 32'h5DC);
    cmp(CORE_BUCK_OUTPUT, 12'h5DC);
    INPUT_UNDERVOLTAGE_LOCK <= 1'b1;
    repeat (3) @(posedge MCLK);
    cmp(CORE_BUCK_OUTPUT, core_def);
    INPUT_UNDERVOLTAGE_LOCK <= 1'b0;
    wait_pin(1'b1, 80);
    repeat (6) @(posedge MCLK);
    cmp({CORE_BUCK_ON, SYSTEM_BUCK_ON, MEMORY_BUCK_ON, REG_ON}, en);
    cmp(POWER_OK_N_I, 1'b0);
    RAIL_LOW <= 5'h04;
    repeat (4) @(posedge MCLK);
    cmp(POWER_OK_N_I, 1'b0);
    RAIL_LOW <= 5'h00;
    repeat (4) @(posedge MCLK);
    cmp(POWER_OK_N_I, 1'b1);
    for (int r = 0; r < 5; r++) begin
      RAIL_LOW <= 5'h01 << r;
      repeat (3) @(posedge MCLK);
      cmp(POWER_OK_N_I, 1'b0);
      apb(1'b0, `PRPO_OFF_STATUS, 32'h0);
      cmp(q[5:1], 5'h01 << r);
      repeat (2) @(posedge MCLK);
      cmp(POWER_OK_N_I, 1'b1);
      apb(1'b0, `PRPO_OFF_STATUS, 32'h0);
      cmp(q[5:1], 5'h01 << r);
      RAIL_LOW <= 5'h00;
      apb(1'b1, `PRPO_OFF_MASK, {`PRPO_MASK_RST, 1'b0} | (32'h2 << r));
      RAIL_LOW <= 5'h01 << r;
      repeat (4) @(posedge MCLK);
      cmp(POWER_OK_N_I, 1'b1);
      RAIL_LOW <= 5'h00;
      apb(1'b1, `PRPO_OFF_MASK, {`PRPO_MASK_RST, 1'b0});
    end
    // supply-fail below, neither, above, neither (battery-low above, neither, below, neither): each flag must hold between thresholds
    for (int k = 0; k < 4; k++) begin
      {SFAIL_BELOW, SFAIL_ABOVE} <= k[0] ? 2'b00 : (k[1] ? 2'b01 : 2'b10);
      {BLOW_BELOW, BLOW_ABOVE} <= k[0] ? 2'b00 : (k[1] ? 2'b10 : 2'b01);
      repeat (3) @(posedge MCLK);
      cmp({SUPPLY_FAIL_FLAG, BATTERY_LOW_FLAG}, {~k[1], k[1]});
    end
    apb(1'b0, 8'h40, 32'h0);
    cmp(err, 1'b1);
    cmp(q, 32'h00000000);
    stop_test();
  end
endmodule : test_prpo_ctrl
`default_nettype wire
